// >>> src/fcc_pkg.sv
// constants, types and timeout tables for the flash command controller
package fcc_pkg;
   // ------------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned PAGE_BYTES  = 1024;
   localparam int unsigned PAGE_LSB    = 10;
   localparam int unsigned PAGE_W      = 6;
   localparam int unsigned INFO_BYTES  = 256;
   localparam int unsigned INFO_W      = 8;

   // ------------------------------------------------------------------
   // command register layout
   // ------------------------------------------------------------------
   localparam int unsigned CODE_LSB    = 0;
   localparam int unsigned CODE_W      = 5;
   localparam int unsigned FAIL_BIT    = 5;
   localparam int unsigned TSEL_LSB    = 5;
   localparam int unsigned TSEL_W      = 3;
   localparam int unsigned WVFY_BIT    = 7;
   localparam logic [7:0]  CMD_RESET   = 8'h80;
   localparam logic [4:0]  CODE_RESET  = 5'h00;
   localparam logic [2:0]  TSEL_RESET  = 3'h0;

   // command codes
   localparam logic [4:0]  CMD_NOP        = 5'h00;
   localparam logic [4:0]  CMD_MAIN_WRITE = 5'h02;
   localparam logic [4:0]  CMD_MAIN_ERASE = 5'h03;
   localparam logic [4:0]  CMD_INFO_WRITE = 5'h0a;
   localparam logic [4:0]  CMD_INFO_ERASE = 5'h0b;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ  = 10_000_000;
   localparam int unsigned PRESCALE    = 256;
   localparam int unsigned TICK_W      = 14;

   typedef enum logic [1:0] {
      FCC_OP_READ  = 2'b00,
      FCC_OP_WRITE = 2'b01,
      FCC_OP_ERASE = 2'b10
   } fcc_op_t;

   typedef enum logic [2:0] {
      FCC_IDLE  = 3'b000,
      FCC_CHECK = 3'b001,
      FCC_WAIT  = 3'b010,
      FCC_VREQ  = 3'b011,
      FCC_VWAIT = 3'b100,
      FCC_DONE  = 3'b101
   } fcc_state_t;

   // time limit in program clock cycles
   function automatic logic [13:0] fcc_limit(input logic erase, input logic [2:0] tsel);
      logic [13:0] w;
      logic [13:0] e;
      w = 14'h0037;
      e = 14'h153b;
      unique case (tsel)
         3'h0: begin w = 14'h0037; e = 14'h153b; end
         3'h1: begin w = 14'h003c; e = 14'h1741; end
         3'h2: begin w = 14'h0041; e = 14'h1934; end
         3'h3: begin w = 14'h0045; e = 14'h1af1; end
         3'h4: begin w = 14'h004b; e = 14'h1cf0; end
         3'h5: begin w = 14'h0050; e = 14'h1ee2; end
         3'h6: begin w = 14'h0055; e = 14'h20d4; end
         3'h7: begin w = 14'h0059; e = 14'h22b9; end
      endcase
      return erase ? e : w;
   endfunction
endpackage

// >>> src/fcc_timer.sv
// program clock divider and command timeout counter
`timescale 1ns/100ps
module fcc_timer #(
   parameter int unsigned p_prescale = fcc_pkg::PRESCALE
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_clear,
   input  wire logic        i_run,
   input  wire logic [7:0]  i_divider,
   input  wire logic [13:0] i_limit,
   output logic             o_expired
);
   typedef struct packed {
      logic [7:0]  pre;
      logic [7:0]  div;
      logic [13:0] ticks;
      logic        expired;
   } fcc_tmr_t;

   fcc_tmr_t st_r;
   fcc_tmr_t st_nxt;
   logic     pre_wrap;

   // ------------------------------------------------------------------
   // one program clock = prescale * (divider + 1) system clocks
   // ------------------------------------------------------------------
   // prescale then divider
   always_comb begin
      st_nxt   = st_r;
      pre_wrap = (st_r.pre == 8'((p_prescale - 1)));
      if (i_clear) begin
         st_nxt = '0;
      end else if (i_run && !st_r.expired) begin
         st_nxt.pre = pre_wrap ? 8'h00 : st_r.pre + 8'h01;
         if (pre_wrap) begin
            if (st_r.div == i_divider) begin
               st_nxt.div   = 8'h00;
               st_nxt.ticks = st_r.ticks + 14'h0001;
            end else begin
               st_nxt.div = st_r.div + 8'h01;
            end
         end
         st_nxt.expired = (st_nxt.ticks >= i_limit);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_expired = st_r.expired;

   a_expiry_sticky: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_r.expired && !i_clear |=> st_r.expired && $stable(st_r.ticks))
      else $error("expired timer changed without clear");
endmodule

// >>> src/fcc_controller.sv
// flash command controller: command register, sequencer, verify and cpu hold
//
// Contract
// - software starts storage commands by writing the command register; fetches bypass it.
// - the cpu is held idle from command acceptance until the command has finished.
// - the main array is 64K bytes in 1024-byte pages and erase works on one page.
// - a separate 256-byte information sector is selected by its own commands.
// - a five-bit command code in the low register bits picks the operation and reads back.
// - after each byte write the location is read back and a mismatch clears the verify flag.
// - the verify flag returns to one whenever another programming command executes.
// - the failure flag is set when the latest command did not complete correctly.
// - reading leaves the failure flag alone; only a new command clears it.
// - an out-of-range or protected address refuses the command and sets failure.
// - a three-bit selector sets the write and erase time limit in program clocks.
// - one program clock is the system clock divided by 256 then by divider plus one.
`timescale 1ns/100ps
module fcc_controller #(
   parameter int unsigned p_prescale = fcc_pkg::PRESCALE
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic [15:0] i_cmd_addr,
   input  wire logic [7:0]  i_cmd_data,
   input  wire logic [7:0]  i_program_clock_divider,
   input  wire logic        i_protect_en,
   input  wire logic [5:0]  i_protect_lo_page,
   input  wire logic [5:0]  i_protect_hi_page,
   input  wire logic        i_flash_done,
   input  wire logic [7:0]  i_flash_rdata,
   output logic [7:0]       o_reg_rdata,
   output logic             o_cpu_hold,
   output logic             o_flash_req,
   output logic [1:0]       o_flash_op,
   output logic             o_flash_info_sector,
   output logic [15:0]      o_flash_addr,
   output logic [7:0]       o_flash_wdata,
   output logic             o_busy
);
   typedef struct packed {
      fcc_pkg::fcc_state_t state;
      logic [4:0]          code;
      logic [2:0]          tsel;
      logic                fail;
      logic                wvfy;
      logic                hold;
      logic                req;
      fcc_pkg::fcc_op_t    op;
      logic                erase;
      logic                info;
      logic [15:0]         addr;
      logic [7:0]          wdata;
      logic [7:0]          rdata;
   } fcc_ctl_t;

   fcc_ctl_t    st_r;
   fcc_ctl_t    st_nxt;
   logic        expired;
   logic        tmr_clear;
   logic        tmr_run;
   logic        known_code;
   logic        is_write;
   logic        is_info;
   logic        addr_bad;
   logic [5:0]  page;

   // ------------------------------------------------------------------
   // command decode and address checks
   // ------------------------------------------------------------------
   always_comb begin
      is_info    = (st_r.code == fcc_pkg::CMD_INFO_WRITE) ||
                   (st_r.code == fcc_pkg::CMD_INFO_ERASE);
      is_write   = (st_r.code == fcc_pkg::CMD_MAIN_WRITE) ||
                   (st_r.code == fcc_pkg::CMD_INFO_WRITE);
      known_code = is_info || is_write || (st_r.code == fcc_pkg::CMD_MAIN_ERASE);
      page       = st_r.addr[15:10];
      // information sector holds only 256 bytes
      // protected page range refuses main-array commands
      addr_bad   = is_info ? (st_r.addr[15:8] != 8'h00)
                           : (i_protect_en && page >= i_protect_lo_page &&
                              page <= i_protect_hi_page);
   end

   // selector and command kind pick the limit
   fcc_timer #(
      .p_prescale (p_prescale)
   ) u_timer (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_clear    (tmr_clear),
      .i_run      (tmr_run),
      .i_divider  (i_program_clock_divider),
      .i_limit    (fcc_pkg::fcc_limit(st_r.erase, st_r.tsel)),
      .o_expired  (expired)
   );

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      st_nxt.req = 1'b0;
      tmr_clear = (st_r.state == fcc_pkg::FCC_CHECK);
      tmr_run   = (st_r.state == fcc_pkg::FCC_WAIT) || (st_r.state == fcc_pkg::FCC_VREQ) ||
                  (st_r.state == fcc_pkg::FCC_VWAIT);
      unique case (st_r.state)
         fcc_pkg::FCC_IDLE: begin
            // command write starts a sequence; fail cleared by the new command
            if (i_reg_wr) begin
               st_nxt.code  = i_reg_wdata[4:0];
               st_nxt.tsel  = i_reg_wdata[7:5];
               st_nxt.addr  = i_cmd_addr;
               st_nxt.wdata = i_cmd_data;
               st_nxt.fail  = 1'b0;
               st_nxt.hold  = 1'b1;
               st_nxt.state = fcc_pkg::FCC_CHECK;
            end
         end
         fcc_pkg::FCC_CHECK: begin
            if (st_r.code == fcc_pkg::CMD_NOP) begin
               st_nxt.state = fcc_pkg::FCC_DONE;
            end else if (!known_code || addr_bad) begin
               st_nxt.fail  = 1'b1;
               st_nxt.state = fcc_pkg::FCC_DONE;
            end else begin
               // erase acts on the whole page holding the address
               st_nxt.req   = 1'b1;
               st_nxt.op    = is_write ? fcc_pkg::FCC_OP_WRITE : fcc_pkg::FCC_OP_ERASE;
               st_nxt.erase = !is_write;
               st_nxt.info  = is_info;
               // verify flag back to one on a programming command
               if (is_write) begin
                  st_nxt.wvfy = 1'b1;
               end
               st_nxt.state = fcc_pkg::FCC_WAIT;
            end
         end
         fcc_pkg::FCC_WAIT: begin
            if (i_flash_done) begin
               st_nxt.state = st_r.erase ? fcc_pkg::FCC_DONE : fcc_pkg::FCC_VREQ;
            end else if (expired) begin
               // timeout ends the command with failure
               st_nxt.fail  = 1'b1;
               st_nxt.state = fcc_pkg::FCC_DONE;
            end
         end
         fcc_pkg::FCC_VREQ: begin
            st_nxt.req   = 1'b1;
            st_nxt.op    = fcc_pkg::FCC_OP_READ;
            st_nxt.state = fcc_pkg::FCC_VWAIT;
         end
         fcc_pkg::FCC_VWAIT: begin
            if (i_flash_done) begin
               if (i_flash_rdata != st_r.wdata) begin
                  st_nxt.wvfy = 1'b0;
               end
               st_nxt.state = fcc_pkg::FCC_DONE;
            end else if (expired) begin
               st_nxt.fail  = 1'b1;
               st_nxt.state = fcc_pkg::FCC_DONE;
            end
         end
         fcc_pkg::FCC_DONE: begin
            st_nxt.hold  = 1'b0;
            st_nxt.state = fcc_pkg::FCC_IDLE;
         end
         default: begin
            st_nxt.hold  = 1'b0;
            st_nxt.state = fcc_pkg::FCC_IDLE;
         end
      endcase
      // code reads back in the low bits; reads have no side effect
      st_nxt.rdata = {st_nxt.wvfy, 1'b0, st_nxt.fail, st_nxt.code};
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r       <= '0;
         st_r.state <= fcc_pkg::FCC_IDLE;
         st_r.code  <= fcc_pkg::CODE_RESET;
         st_r.tsel  <= fcc_pkg::TSEL_RESET;
         st_r.wvfy  <= 1'b1;
         st_r.rdata <= fcc_pkg::CMD_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_reg_rdata         = st_r.rdata;
   assign o_cpu_hold          = st_r.hold;
   assign o_flash_req         = st_r.req;
   assign o_flash_op          = st_r.op;
   assign o_flash_info_sector = st_r.info;
   assign o_flash_addr        = st_r.addr;
   assign o_flash_wdata       = st_r.wdata;
   assign o_busy              = st_r.hold;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence s_cmd_taken;
      st_r.state == fcc_pkg::FCC_IDLE && i_reg_wr;
   endsequence

   sequence s_refused;
      st_r.state == fcc_pkg::FCC_CHECK && st_r.code != fcc_pkg::CMD_NOP &&
      (!known_code || addr_bad);
   endsequence

   a_hold_on_cmd: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_cmd_taken |=> o_cpu_hold && !st_r.fail) else $error("hold not raised on command");
   a_code_readback: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_cmd_taken |=> o_reg_rdata[4:0] == $past(i_reg_wdata[4:0]))
      else $error("command code does not read back");
   a_refuse_fails: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_refused |=> st_r.fail && !o_flash_req ##1 !o_cpu_hold)
      else $error("refused command not flagged");
   a_verify_reset: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_r.state == fcc_pkg::FCC_CHECK && is_write && known_code && !addr_bad
      |=> o_reg_rdata[7] && o_flash_req) else $error("verify flag not restored");
   a_verify_miss: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_r.state == fcc_pkg::FCC_VWAIT && i_flash_done && i_flash_rdata != st_r.wdata
      |=> !o_reg_rdata[7]) else $error("mismatch did not clear verify");
   a_fail_sticky: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_r.state == fcc_pkg::FCC_IDLE && !i_reg_wr && st_r.fail |=> st_r.fail)
      else $error("fail cleared without command");
   a_timeout_end: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_r.state == fcc_pkg::FCC_WAIT && expired && !i_flash_done
      |=> o_reg_rdata[5] ##1 !o_cpu_hold) else $error("timeout did not end command");
   a_hold_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_cpu_hold) |-> $past(st_r.state) == fcc_pkg::FCC_DONE)
      else $error("hold dropped before completion");
endmodule

// >>> dv/fcc_flash_model.sv
// behavioural flash array answering the controller's request pulses
`timescale 1ns/100ps
module fcc_flash_model (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic [1:0]  i_op,
   input  wire logic        i_info,
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic [7:0]  i_delay,
   input  wire logic        i_corrupt,
   input  wire logic        i_mute,
   output logic             o_done,
   output logic [7:0]       o_rdata
);
   logic [7:0] mem [0:131071];
   logic [7:0] cnt;
   logic [7:0] rd;
   logic       busy;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // released data lines show the inverse of the last byte, never a stale copy
   assign o_rdata = o_done ? rd : ~rd;
   always @(posedge i_clock or negedge i_rst_n) begin
      o_done <= 1'b0;
      if (!i_rst_n) begin
         busy <= 1'b0;
         rd   <= 8'h00;
      end else if (i_req) begin
         busy <= !i_mute;
         cnt  <= i_delay;
      end else if (busy && cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else if (busy) begin
         busy   <= 1'b0;
         o_done <= 1'b1;
         rd     <= mem[{i_info, i_addr}] ^ {7'h00, i_corrupt};
         if (i_op == 2'b01) mem[{i_info, i_addr}] <= i_wdata;
         for (int k = 0; k < 1024; k++) begin
            if (i_op == 2'b10 && (!i_info || k < 256))
               mem[{i_info, i_addr[15:10], 10'(k)}] <= 8'hff;
         end
      end
   end
endmodule

// >>> dv/tb.sv
// self-checking bench for the flash command controller against a behavioural array
`timescale 1ns/100ps
module tb;
   localparam int unsigned PRE = 4;
   logic        i_clock = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_protect_en = 1'b0;
   logic [7:0]  i_reg_wdata = 8'h00, i_cmd_data = 8'h00, i_program_clock_divider = 8'h00;
   logic [15:0] i_cmd_addr = 16'h0000, o_flash_addr, seen_addr;
   logic [5:0]  i_protect_lo_page = 6'h00, i_protect_hi_page = 6'h00;
   logic [7:0]  o_reg_rdata, o_flash_wdata, i_flash_rdata, fl_delay = 8'h00;
   logic        o_cpu_hold, o_flash_req, o_flash_info_sector, o_busy, i_flash_done, seen_info;
   logic        fl_corrupt = 1'b0, fl_mute = 1'b0;
   logic [1:0]  o_flash_op;
   logic [1:0]  ops [$];
   int          miscompares = 0, tests_run = 0;
   fcc_controller #(
      .p_prescale (PRE)
   ) u_dut (
      .i_clock                 (i_clock),
      .i_rst_n                 (i_rst_n),
      .i_reg_wr                (i_reg_wr),
      .i_reg_wdata             (i_reg_wdata),
      .i_cmd_addr              (i_cmd_addr),
      .i_cmd_data              (i_cmd_data),
      .i_program_clock_divider (i_program_clock_divider),
      .i_protect_en            (i_protect_en),
      .i_protect_lo_page       (i_protect_lo_page),
      .i_protect_hi_page       (i_protect_hi_page),
      .i_flash_done            (i_flash_done),
      .i_flash_rdata           (i_flash_rdata),
      .o_reg_rdata             (o_reg_rdata),
      .o_cpu_hold              (o_cpu_hold),
      .o_flash_req             (o_flash_req),
      .o_flash_op              (o_flash_op),
      .o_flash_info_sector     (o_flash_info_sector),
      .o_flash_addr            (o_flash_addr),
      .o_flash_wdata           (o_flash_wdata),
      .o_busy                  (o_busy)
   );
   fcc_flash_model u_flash (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(o_flash_req), .i_op(o_flash_op),
      .i_info(o_flash_info_sector), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata),
      .i_delay(fl_delay), .i_corrupt(fl_corrupt), .i_mute(fl_mute), .o_done(i_flash_done),
      .o_rdata(i_flash_rdata)
   );
   always #50 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      if (o_flash_req === 1'b1) begin
         ops.push_back(o_flash_op);
         seen_addr <= o_flash_addr;
         seen_info <= o_flash_info_sector;
      end
   end
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] data);
      @(posedge i_clock);
      i_reg_wr    <= 1'b1;
      i_reg_wdata <= cmd;
      i_cmd_addr  <= addr;
      i_cmd_data  <= data;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
   endtask
   task automatic exec(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] data,
                       input logic [7:0] exp, input int n, output int cyc);
      ops.delete();
      pulse(cmd, addr, data);
      cyc = 0;
      do begin
         @(negedge i_clock);
         cyc++;
      end while (o_cpu_hold !== 1'b0 && cyc < 30000);
      check("register", 16'(exp), 16'(o_reg_rdata));
      check("requests", 16'(n), 16'(ops.size()));
      check("hold", 16'h0000, 16'({o_cpu_hold, o_busy}));
   endtask
   task automatic wrap_up();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_write();
      int cyc;
      check("reset register", 16'h0080, 16'(o_reg_rdata));
      fl_delay <= 8'd20;
      pulse(8'he2, 16'h1234, 8'h5a);
      // the second command arrives while busy and must vanish
      exec(8'he3, 16'h2000, 8'h00, 8'h82, 2, cyc);
      check("op order", 16'h0004, 16'({ops[0], ops[1]}));
      check("address", 16'h1234, seen_addr);
      check("stored", 16'h005a, 16'(u_flash.mem[17'h01234]));
      check("held long", 16'h0001, 16'(cyc > 40));
      fl_delay <= 8'd0;
   endtask
   task automatic t_verify();
      int cyc;
      fl_corrupt <= 1'b1;
      exec(8'he2, 16'h2000, 8'ha5, 8'h02, 2, cyc);
      fl_corrupt <= 1'b0;
      exec(8'he3, 16'h2400, 8'h00, 8'h03, 1, cyc);
      exec(8'he2, 16'h2001, 8'h3c, 8'h82, 2, cyc);
   endtask
   task automatic t_info();
      int cyc;
      exec(8'hea, 16'h00ff, 8'h77, 8'h8a, 2, cyc);
      check("info select", 16'h0001, 16'(seen_info));
      check("info byte", 16'h0077, 16'(u_flash.mem[17'h100ff]));
      check("main kept", 16'h00ff, 16'(u_flash.mem[17'h000ff]));
      exec(8'hea, 16'h0100, 8'h77, 8'haa, 0, cyc);
      exec(8'heb, 16'h0000, 8'h00, 8'h8b, 1, cyc);
      check("info erased", 16'h00ff, 16'(u_flash.mem[17'h100ff]));
   endtask
   task automatic t_protect();
      int cyc;
      @(posedge i_clock);
      i_protect_en      <= 1'b1;
      i_protect_lo_page <= 6'h04;
      i_protect_hi_page <= 6'h05;
      exec(8'he2, 16'h1000, 8'h01, 8'ha2, 0, cyc);
      repeat (10) @(negedge i_clock);
      check("fail kept", 16'h00a2, 16'(o_reg_rdata));
      exec(8'he2, 16'h17ff, 8'h01, 8'ha2, 0, cyc);
      exec(8'he2, 16'h0fff, 8'h01, 8'h82, 2, cyc);
      exec(8'he2, 16'h1800, 8'h02, 8'h82, 2, cyc);
      exec(8'hff, 16'h0000, 8'h00, 8'hbf, 0, cyc);
      exec(8'h00, 16'h0000, 8'h00, 8'h80, 0, cyc);
      @(posedge i_clock);
      i_protect_en <= 1'b0;
   endtask
   task automatic t_erase();
      int cyc;
      u_flash.mem[17'h003ff] = 8'h33;
      u_flash.mem[17'h00400] = 8'h11;
      u_flash.mem[17'h007ff] = 8'h44;
      u_flash.mem[17'h00800] = 8'h22;
      exec(8'he3, 16'h0555, 8'h00, 8'h83, 1, cyc);
      check("erase op", 16'h0002, 16'(ops[0]));
      check("page start", 16'h00ff, 16'(u_flash.mem[17'h00400]));
      check("page end", 16'h00ff, 16'(u_flash.mem[17'h007ff]));
      check("below page", 16'h0033, 16'(u_flash.mem[17'h003ff]));
      check("above page", 16'h0022, 16'(u_flash.mem[17'h00800]));
   endtask
   task automatic t_reset();
      // reset lands while a write is in flight
      pulse(8'he2, 16'h0040, 8'h12);
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      @(negedge i_clock);
      check("reset register", 16'h0080, 16'(o_reg_rdata));
      check("reset hold", 16'h0000, 16'({o_cpu_hold, o_busy, o_flash_req}));
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(negedge i_clock);
      check("after reset", 16'h0080, 16'(o_reg_rdata));
   endtask
   task automatic t_timeout();
      int lims [4] = '{55, 60, 55, 5435};
      int cyc;
      int lo;
      logic [4:0] code;
      fl_mute <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge i_clock);
         i_program_clock_divider <= (k == 2) ? 8'h01 : 8'h00;
         lo = lims[k] * PRE * ((k == 2) ? 2 : 1);
         code = (k == 3) ? 5'h03 : 5'h02;
         exec({2'b00, k == 1, code}, 16'h3000, 8'h00, {3'b101, code}, 1, cyc);
         check("timeout span", 16'h0001, 16'(cyc >= lo - 8 && cyc <= lo + 16));
      end
      fl_mute <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(negedge i_clock);
      t_write();
      t_verify();
      t_info();
      t_protect();
      t_erase();
      t_reset();
      t_timeout();
      wrap_up();
   end
   initial begin
      #(100 * 40000);
      // a hung wait counts as a mismatch
      miscompares++;
      wrap_up();
   end
endmodule
